// File: hw/cfi_pkg.sv
// Constants, register layout and carrier types for the CAN FIFO event flag block.
// Assumes an APB slave at 125 MHz with word-aligned 32-bit registers.
//
// Functional notes
// R1 - There are sixteen event enable and flag registers, one per message FIFO, numbered 0 to 15.
// R2 - Bit 26 enables the not-full event of a FIFO onto the interrupt.
// R3 - Bit 25 enables the transmit half-full event onto the interrupt.
// R4 - Bit 24 enables the transmit empty event onto the interrupt.
// R5 - Bit 19 enables the receive overflow event onto the interrupt.
// R6 - Bit 18 enables the receive full event onto the interrupt.
// R7 - Bit 17 enables the receive half-full event onto the interrupt.
// R8 - Bit 16 enables the receive not-empty event onto the interrupt.
// R9 - In transmit direction bit 10 reads one while the FIFO has room and zero when full.
// R10 - In receive direction the not-full flag always reads zero.
// R11 - The fill-state flags are read-only live mirrors of the FIFO state and ignore writes.
// R12 - Bits 31 to 27, 23 to 20 and 15 to 11 read zero and ignore writes.
// R13 - The overflow flag is set when a message arrives at a full receive FIFO and stays until written zero.
// R14 - A FIFO's request is the OR over the seven events of flag AND enable.
package cfi_pkg;

    localparam int CFI_NUM_FIFOS = 16;
    localparam int CFI_IDX_W = 4;

    // Per-FIFO registers at byte offset 4*n
    localparam logic [11:0] CFI_FIFO_BASE = 12'h000;
    localparam logic [11:0] CFI_STAT_ADDR = 12'h040;
    localparam logic [11:0] CFI_MASK_ADDR = 12'h044;
    localparam logic [11:0] CFI_PEND_ADDR = 12'h048;

    // Field positions
    localparam int CFI_BIT_TX_ROOM_EN = 26;
    localparam int CFI_BIT_TX_HALF_EN = 25;
    localparam int CFI_BIT_TX_DRAIN_EN = 24;
    localparam int CFI_BIT_RX_OVR_EN = 19;
    localparam int CFI_BIT_RX_FULL_EN = 18;
    localparam int CFI_BIT_RX_HALF_EN = 17;
    localparam int CFI_BIT_RX_PEND_EN = 16;
    localparam int CFI_BIT_TX_ROOM_F = 10;
    localparam int CFI_BIT_TX_HALF_F = 9;
    localparam int CFI_BIT_TX_DRAIN_F = 8;
    localparam int CFI_BIT_RX_OVR_F = 3;
    localparam int CFI_BIT_RX_FULL_F = 2;
    localparam int CFI_BIT_RX_HALF_F = 1;
    localparam int CFI_BIT_RX_PEND_F = 0;

    localparam logic [31:0] CFI_EN_MASK = 32'h070F_0000;
    localparam logic [6:0] CFI_EN_RESET = 7'h00;
    localparam logic [15:0] CFI_ZERO16 = 16'h0000;

    typedef struct packed {
        logic direction_transmit;
        logic full;
        logic half;
        logic empty;
        logic arrival;
    } cfi_fifo_state_s;

    typedef struct packed {
        logic tx_room_irq_en;
        logic tx_half_irq_en;
        logic tx_drained_irq_en;
        logic rx_overrun_irq_en;
        logic rx_complete_fill_irq_en;
        logic rx_half_irq_en;
        logic rx_pending_irq_en;
    } cfi_enables_s;

endpackage

// File: hw/cfi_fifo_slot.sv
// One FIFO's enable bits, overflow flag, live flags and request.
// Assumes write strobes arrive already decoded and qualified by the clock enable.
`timescale 1ns/1ps
module cfi_fifo_slot
    import cfi_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire cfi_pkg::cfi_fifo_state_s state,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata,
    output logic req
);
    import cfi_pkg::*;

    cfi_enables_s en_reg;
    logic ovr_reg;
    logic ovr_next;
    logic tx_room_flag;
    logic tx_half_flag;
    logic tx_drained_flag;
    logic rx_overrun_flag;
    logic rx_complete_fill_flag;
    logic rx_half_flag;
    logic rx_pending_flag;
    logic ovr_event;
    logic tx_dir;

    // ------------------------------------------------------------
    // Live flags
    // ------------------------------------------------------------
    assign tx_dir = state.direction_transmit;
    assign tx_room_flag = tx_dir & ~state.full; // R9 R10 R11
    assign tx_half_flag = tx_dir & state.half; // R11
    assign tx_drained_flag = tx_dir & state.empty; // R11
    assign rx_complete_fill_flag = ~tx_dir & state.full; // R11
    assign rx_half_flag = ~tx_dir & state.half; // R11
    assign rx_pending_flag = ~tx_dir & ~state.empty; // R11
    assign rx_overrun_flag = ovr_reg;

    // Set wins over a software clear in the same cycle
    assign ovr_event = ~tx_dir & state.full & state.arrival;
    assign ovr_next = ovr_event | (ovr_reg & ~(wr_en & ~wdata[CFI_BIT_RX_OVR_F])); // R13

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= CFI_EN_RESET;
            ovr_reg <= 1'b0;
        end else if (ce) begin
            ovr_reg <= ovr_next;
            if (wr_en) begin
                en_reg <= {wdata[CFI_BIT_TX_ROOM_EN], wdata[CFI_BIT_TX_HALF_EN], // R2 R3
                           wdata[CFI_BIT_TX_DRAIN_EN], wdata[CFI_BIT_RX_OVR_EN], // R4 R5
                           wdata[CFI_BIT_RX_FULL_EN], wdata[CFI_BIT_RX_HALF_EN], // R6 R7
                           wdata[CFI_BIT_RX_PEND_EN]}; // R8
            end
        end
    end

    // ------------------------------------------------------------
    // Read word and request
    // ------------------------------------------------------------
    always_comb begin
        rdata = '0; // R12
        rdata[CFI_BIT_TX_ROOM_EN] = en_reg.tx_room_irq_en;
        rdata[CFI_BIT_TX_HALF_EN] = en_reg.tx_half_irq_en;
        rdata[CFI_BIT_TX_DRAIN_EN] = en_reg.tx_drained_irq_en;
        rdata[CFI_BIT_RX_OVR_EN] = en_reg.rx_overrun_irq_en;
        rdata[CFI_BIT_RX_FULL_EN] = en_reg.rx_complete_fill_irq_en;
        rdata[CFI_BIT_RX_HALF_EN] = en_reg.rx_half_irq_en;
        rdata[CFI_BIT_RX_PEND_EN] = en_reg.rx_pending_irq_en;
        rdata[CFI_BIT_TX_ROOM_F] = tx_room_flag;
        rdata[CFI_BIT_TX_HALF_F] = tx_half_flag;
        rdata[CFI_BIT_TX_DRAIN_F] = tx_drained_flag;
        rdata[CFI_BIT_RX_OVR_F] = rx_overrun_flag;
        rdata[CFI_BIT_RX_FULL_F] = rx_complete_fill_flag;
        rdata[CFI_BIT_RX_HALF_F] = rx_half_flag;
        rdata[CFI_BIT_RX_PEND_F] = rx_pending_flag;
    end

    assign req = (tx_room_flag & en_reg.tx_room_irq_en) // R14
               | (tx_half_flag & en_reg.tx_half_irq_en)
               | (tx_drained_flag & en_reg.tx_drained_irq_en)
               | (rx_overrun_flag & en_reg.rx_overrun_irq_en)
               | (rx_complete_fill_flag & en_reg.rx_complete_fill_irq_en)
               | (rx_half_flag & en_reg.rx_half_irq_en)
               | (rx_pending_flag & en_reg.rx_pending_irq_en);

endmodule

// File: hw/cfi_top.sv
// APB register file for sixteen CAN FIFO event enable and flag registers.
// Assumes FIFO fill state comes from the same clock domain; a sticky
// status/mask pair turns per-FIFO request rising edges into one interrupt.
`timescale 1ns/1ps
module cfi_top
    import cfi_pkg::*;
#(
    parameter int NUM_FIFOS = CFI_NUM_FIFOS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cfi_pkg::cfi_fifo_state_s [NUM_FIFOS-1:0] fifo_state,
    output logic [NUM_FIFOS-1:0] fifo_req,
    output logic irq
);
    import cfi_pkg::*;

    if (NUM_FIFOS < 1 || NUM_FIFOS > CFI_NUM_FIFOS) begin : g_bad_fifos
        $error("NUM_FIFOS out of range");
    end

    logic [31:0] slot_rdata [NUM_FIFOS];
    logic [NUM_FIFOS-1:0] slot_wr;
    logic [NUM_FIFOS-1:0] req_vec;
    logic [NUM_FIFOS-1:0] req_prev_reg;
    logic [NUM_FIFOS-1:0] stat_reg;
    logic [NUM_FIFOS-1:0] stat_next;
    logic [NUM_FIFOS-1:0] mask_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pslverr_reg;
    logic access;
    logic wr_acc;
    logic answer_ready_reg;
    logic fifo_hit;
    logic [CFI_IDX_W-1:0] fifo_idx;
    logic stat_hit;
    logic mask_hit;
    logic pend_hit;
    logic addr_ok;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // A setup cycle lost to a low clock enable costs one wait state,
    // so read data and error never come from a stale capture
    assign access = psel & penable & pready;
    assign wr_acc = access & pwrite;
    assign fifo_idx = paddr[CFI_IDX_W+1:2];
    assign fifo_hit = (paddr[11:CFI_IDX_W+2] == CFI_FIFO_BASE[11:CFI_IDX_W+2])
                    && (paddr[1:0] == 2'h0) && (32'(fifo_idx) < NUM_FIFOS); // R1
    assign stat_hit = (paddr == CFI_STAT_ADDR);
    assign mask_hit = (paddr == CFI_MASK_ADDR);
    assign pend_hit = (paddr == CFI_PEND_ADDR);
    assign addr_ok = fifo_hit | stat_hit | mask_hit | pend_hit;
    assign pready = ce & answer_ready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // Per-FIFO slots
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_FIFOS; g++) begin : g_slot
            assign slot_wr[g] = wr_acc & fifo_hit & (fifo_idx == CFI_IDX_W'(g));
            cfi_fifo_slot cfi_fifo_slot_inst (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .state(fifo_state[g]),
                .wr_en(slot_wr[g]),
                .wdata(pwdata),
                .rdata(slot_rdata[g]),
                .req(req_vec[g])
            );
        end
    endgenerate

    assign fifo_req = req_vec;

    // ------------------------------------------------------------
    // Sticky status, write one to clear
    // ------------------------------------------------------------
    // Rising request sets; a new edge beats a clear in the same cycle
    assign stat_next = (req_vec & ~req_prev_reg)
                     | (stat_reg & ~((wr_acc & stat_hit) ? pwdata[NUM_FIFOS-1:0] : '0));
    assign irq = |(stat_reg & mask_reg);

    always_comb begin
        prdata_next = '0;
        if (fifo_hit) begin
            prdata_next = slot_rdata[fifo_idx];
        end else if (stat_hit) begin
            prdata_next = 32'(stat_reg);
        end else if (mask_hit) begin
            prdata_next = 32'(mask_reg);
        end else if (pend_hit) begin
            prdata_next = 32'(req_vec);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prev_reg <= '0;
            stat_reg <= '0;
            mask_reg <= '0;
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
            answer_ready_reg <= 1'b0;
        end else if (ce) begin
            req_prev_reg <= req_vec;
            stat_reg <= stat_next;
            if (wr_acc && mask_hit) begin
                mask_reg <= pwdata[NUM_FIFOS-1:0];
            end
            if (psel && !access) begin
                prdata_reg <= pwrite ? '0 : prdata_next;
                pslverr_reg <= ~addr_ok;
                answer_ready_reg <= 1'b1;
            end else if (access) begin
                answer_ready_reg <= 1'b0;
            end
        end
    end

endmodule

// File: testbench/cfi_top_chk.sv
// Port-level checker for the FIFO event flag register block.
// Assumes it is bound to cfi_top and sees only its ports.
`timescale 1ns/1ps
module cfi_top_chk
    import cfi_pkg::*;
#(
    parameter int NUM_FIFOS = CFI_NUM_FIFOS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire cfi_pkg::cfi_fifo_state_s [NUM_FIFOS-1:0] fifo_state,
    input wire logic [NUM_FIFOS-1:0] fifo_req,
    input wire logic irq
);
    import cfi_pkg::*;
    // ----------------
    // Helpers
    // ----------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && pready;
    wire logic bad_a = (paddr[1:0] != 2'h0) || (paddr > 12'h048);
    wire logic rd_reg = acc && !pwrite && !bad_a && (paddr < 12'h040);
    wire logic [3:0] idx = paddr[5:2];
    logic [NUM_FIFOS-1:0] room;
    logic [NUM_FIFOS-1:0] room_q;
    logic [NUM_FIFOS-1:0] req_q;
    always_comb begin
        for (int i = 0; i < NUM_FIFOS; i++) begin
            room[i] = fifo_state[i].direction_transmit && !fifo_state[i].full;
        end
    end
    // Read data is one edge behind the live state
    always_ff @(posedge pclk) begin
        if (ce) begin
            room_q <= room;
            req_q <= fifo_req;
        end
    end
    chk_ready_ce: assert property (!ce |-> !pready) else $error("pready high while frozen");
    chk_ready_next: assert property (psel && !penable && ce |=> pready || !ce)
        else $error("wait state after a clean setup");
    chk_unmapped_err: assert property (acc && bad_a |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && !bad_a |-> !pslverr) else $error("mapped access refused");
    chk_rsvd_zero: assert property (rd_reg |-> (prdata & 32'hF8F0_F800) == 32'h0)
        else $error("unimplemented bits not zero");
    chk_room_flag: assert property (rd_reg |-> prdata[10] == room_q[idx])
        else $error("room flag wrong");
    chk_pend_mirror: assert property (acc && !pwrite && paddr == 12'h048 |-> prdata[15:0] == req_q)
        else $error("pending register differs from requests");
    chk_mask_off: assert property (acc && pwrite && paddr == 12'h044 && pwdata[15:0] == 16'h0 |=> !irq)
        else $error("irq high with mask clear");
    chk_rst_quiet: assert property ($rose(presetn) |-> !irq && !pslverr) else $error("outputs busy after reset");
    cover property (rd_reg);
    cover property (acc && bad_a);
    cover property ($rose(irq));
endmodule
bind cfi_top cfi_top_chk #(.NUM_FIFOS(NUM_FIFOS)) cfi_top_chk_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_state(fifo_state), .fifo_req(fifo_req), .irq(irq));

// File: testbench/cfi_top_bench.sv
// Self-checking bench for the FIFO event flag register block.
// Assumes cfi_top with sixteen FIFOs and an APB slave that may add wait states.
`timescale 1ns/1ps
module cfi_top_bench;
    import cfi_pkg::*;
    // ----------------
    // Stimulus and model
    // ----------------
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, x = 32'h0000_21F7;
    logic [15:0] fifo_req, ovr = 16'h0;
    cfi_fifo_state_s [15:0] st = '0;
    logic [6:0] en [16];
    int error_cnt = 0, num_checks = 0, n;
    cfi_top cfi_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fifo_state(st), .fifo_req(fifo_req), .irq(irq));
    initial forever #4 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] exp_rd(int i);
        logic [31:0] r;
        r = {5'h00, en[i][6:4], 4'h0, en[i][3:0], 12'h000, ovr[i], 3'h0};
        if (st[i].direction_transmit) r[10:8] = {!st[i].full, st[i].half, st[i].empty};
        else r[2:0] = {st[i].full, st[i].half, !st[i].empty};
        return r;
    endfunction
    function automatic logic exp_req(int i);
        logic [31:0] r;
        r = exp_rd(i);
        return |({r[10:8], r[3:0]} & en[i]);
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        if (w && a < 12'h040 && a[1:0] == 2'h0) begin
            en[a[5:2]] = {d[26:24], d[19:16]};
            ovr[a[5:2]] &= d[3];
        end
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end
    // ----------------
    // Tests
    // ----------------
    initial begin
        foreach (en[i]) en[i] = 7'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (n = 0; n < 16; n++) begin
            apb(0, 12'(n * 4), 0);
            chk("reset reg", exp_rd(n), rd);
        end
        $display("test reset done");
        repeat (60) begin
            n = rnd() % 16;
            apb(1, 12'(n * 4), rnd());
            st[n] <= cfi_fifo_state_s'(5'(rnd() & 32'h1E));
            apb(0, 12'(n * 4), 0);
            chk("reg", exp_rd(n), rd);
            chk("req", {31'h0, exp_req(n)}, {31'h0, fifo_req[n]});
        end
        $display("test random done");
        @(posedge pclk);
        st[3] <= cfi_fifo_state_s'(5'h09);
        st[4] <= cfi_fifo_state_s'(5'h01);
        @(posedge pclk);
        st[3].arrival <= 0;
        st[4].arrival <= 0;
        ovr[3] = 1;
        apb(0, 12'h00C, 0);
        chk("overrun set", exp_rd(3), rd);
        apb(0, 12'h010, 0);
        chk("no overrun", exp_rd(4), rd);
        apb(1, 12'h00C, 0);
        apb(0, 12'h00C, 0);
        chk("overrun clear", exp_rd(3), rd);
        apb(0, 12'h04C, 0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(0, 12'h002, 0);
        chk("unaligned", {31'h0, err} | rd, 32'h1);
        apb(1, 12'hFFC, 32'hFFFF_FFFF);
        chk("unmapped write", {31'h0, err}, 32'h1);
        $display("test overrun done");
        // Clock enable low in the setup cycle, then across the access phase
        fork
            apb(0, 12'h00C, 0);
            begin
                ce <= 0;
                @(posedge pclk) ce <= 1;
            end
        join
        chk("stalled setup", exp_rd(3), rd);
        fork
            apb(1, 12'h00C, 32'h0107_0000);
            begin
                @(posedge pclk) ce <= 0;
                repeat (2) @(posedge pclk);
                ce <= 1;
            end
        join
        apb(0, 12'h00C, 0);
        chk("stalled write", exp_rd(3), rd);
        $display("test clock enable done");
        st[5] <= cfi_fifo_state_s'(5'h00);
        apb(1, 12'h014, 0);
        apb(1, 12'h040, 32'hFFFF);
        apb(1, 12'h044, 32'h20);
        apb(1, 12'h014, 32'h0001_0000);
        repeat (3) @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(0, 12'h040, 0);
        chk("status", 32'h20, rd & 32'h20);
        apb(0, 12'h048, 0);
        chk("pending", 32'h20, rd & 32'h20);
        apb(1, 12'h044, 0);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1, 12'h044, 32'h20);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(1, 12'h040, 32'h20);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        print_verdict();
    end
endmodule
